/* File: design/imh_consts.svh */
`ifndef IMH_CONSTS_SVH
`define IMH_CONSTS_SVH

// ***********************************************
// Character codes
// ***********************************************
`define IMH_CHAR_CR        8'h0d
`define IMH_CHAR_SP        8'h20
`define IMH_CHAR_E         8'h45
`define IMH_CHAR_R         8'h52
`define IMH_CHAR_ZERO      8'h30
`define IMH_CHAR_NINE      8'h39

// ***********************************************
// Keywords and identifier range
// ***********************************************
`define IMH_KW_TEXT        88'h53455256494345_4d4f4445
`define IMH_KW_BINARY      88'h5554494c495459_4d4f4445
`define IMH_KW_LEN         5'h0b
`define IMH_LINE_MAX       5'h10
`define IMH_ID_MAX         10'h0ff
`define IMH_ID_DIGITS_MAX  2'h3

// ***********************************************
// Timing and sizes
// ***********************************************
`define IMH_CLK_PERIOD_NS  5
`define IMH_DGRAM_TIME_NS  100000
`define IMH_DGRAM_CYC      ((`IMH_DGRAM_TIME_NS + `IMH_CLK_PERIOD_NS - 1) / `IMH_CLK_PERIOD_NS)
`define IMH_FIFO_DEPTH     8
`define IMH_BYTE_W         8
`define IMH_DLY_W          24

`endif

/* File: design/imh_pkg.sv */
package imh_pkg;

    // ***********************************************
    // Modes and datagram kinds
    // ***********************************************
    typedef enum logic [2:0]
    {
        IMH_NORM   = 3'h0,
        IMH_FINISH = 3'h1,
        IMH_HOLD   = 3'h3,
        IMH_MAINT  = 3'h2,
        IMH_MUTE   = 3'h6
    } imh_mode_e;

    typedef enum logic [1:0]
    {
        IMH_DG_NONE = 2'h0,
        IMH_DG_MEAS = 2'h1,
        IMH_DG_ERR  = 2'h2
    } imh_dg_kind_e;

    // ***********************************************
    // Carriers
    // ***********************************************
    typedef struct packed {
        logic         start;
        imh_dg_kind_e kind;
    } imh_dgram_s;

    typedef struct packed {
        logic text_active;
        logic binary_active;
        logic muted;
    } imh_mode_s;

    typedef struct packed {
        logic [4:0] len;
        logic       ovf;
        logic       text_ok;
        logic       binary_ok;
        logic [7:0] first;
        logic [1:0] ndig;
        logic [9:0] idv;
        logic       bad;
    } imh_line_s;

    typedef struct packed {
        imh_mode_e  mode;
        logic       text;
        logic       addr;
        logic       mine;
        logic [23:0] dly;
        logic       err_pend;
        logic       err_sending;
        imh_line_s  line;
        imh_dgram_s dg;
        logic       err_clear;
        logic       unit_reset;
        logic       enter_text;
        logic       enter_binary;
        imh_mode_s  levels;
    } imh_state_s;

endpackage

/* File: design/imh_fifo.sv */
`timescale 1ns/10ps
`include "imh_consts.svh"

module imh_fifo #(
    parameter int WIDTH = `IMH_BYTE_W,
    parameter int DEPTH = `IMH_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } imh_fifo_ptr_s;

    imh_fifo_ptr_s    st_reg;
    imh_fifo_ptr_s    st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    // Full and empty straight from the count
    assign in_ready  = (st_reg.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st_reg.cnt != '0);
    assign out_data  = mem[st_reg.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        st_next = st_reg;
        if (push)
        begin
            st_next.wr = (st_reg.wr == AW'(DEPTH - 1)) ? '0 : st_reg.wr + 1'b1;
        end
        if (pop)
        begin
            st_next.rd = (st_reg.rd == AW'(DEPTH - 1)) ? '0 : st_reg.rd + 1'b1;
        end
        st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Storage holds no reset; only counted entries are ever read
    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem[st_reg.wr] <= in_data;
        end
    end

endmodule // imh_fifo

/* File: design/imh_cmd_handler.sv */
// What this block does
// - Extended-error request with CR queues exactly one error datagram.
// - Error record is cleared once that datagram has been fully sent.
// - Error datagram takes the next measurement slot, not an extra one.
// - Slots arriving while a long datagram is sent are dropped.
// - In external trigger mode the next trigger carries the error datagram.
// - Reset command with CR requests a full unit reset.
// - Unaddressed text entry command enters human-readable maintenance mode.
// - Text entry may carry a space and identifier 0..255; else silently ignored.
// - Text entry waits for the datagram in flight to finish.
// - Addressed text entry waits one datagram time before answering.
// - Non-addressed modules go silent until exit, then resume quietly.
// - Unaddressed entry is accepted even on a shared multi-module line.
// - Entering text mode starts the identification and settings listing.
// - Binary entry command with CR enters machine-readable maintenance mode.
// - Binary entry identifier must be 0..255; otherwise silently ignored.
// - Binary entry waits for the datagram in flight to finish.
// - Addressed binary entry waits one datagram time before answering.
// - Non-addressed modules stay silent until binary mode exit.
// - CR 0x0d executes a command; space 0x20 precedes the parameter.
// - No echo or error replies; act only on a complete correct command.
`timescale 1ns/10ps
`include "imh_consts.svh"

module imh_cmd_handler #(
    parameter int DGRAM_DELAY_CYC = `IMH_DGRAM_CYC,
    parameter int FIFO_DEPTH      = `IMH_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rstn,
    // Received command bytes
    input  wire logic                    rx_valid,
    output logic                         rx_ready,
    input  wire logic [7:0]              rx_data,
    // Configuration
    input  wire logic [7:0]              module_identifier,
    input  wire logic                    ext_trig_mode,
    // Datagram timing and transmitter
    input  wire logic                    slot_tick,
    input  wire logic                    ext_trig,
    input  wire logic                    tx_busy,
    input  wire logic                    tx_done,
    output imh_pkg::imh_dgram_s          dg_start,
    output logic                         err_clear,
    // Unit control
    output logic                         unit_reset,
    output logic                         enter_maintenance_text_cmd,
    output logic                         enter_maintenance_binary_cmd,
    output imh_pkg::imh_mode_s           mode_levels,
    input  wire logic                    maint_exit,
    // Bytes for the maintenance engine
    output logic                         maint_rx_valid,
    input  wire logic                    maint_rx_ready,
    output logic [7:0]                   maint_rx_data
);

    // ***********************************************
    // Declarations
    // ***********************************************
    localparam imh_pkg::imh_line_s LINE_CLEAR = '{len: 5'h00, ovf: 1'b0, text_ok: 1'b1, binary_ok: 1'b1,
                                                   first: 8'h00, ndig: 2'h0, idv: 10'h000, bad: 1'b0};
    localparam logic [23:0] DLY_LAST = 24'(DGRAM_DELAY_CYC - 1);

    imh_pkg::imh_state_s st_reg;
    imh_pkg::imh_state_s st_next;
    logic                fifo_valid;
    logic                fifo_ready;
    logic [7:0]          fifo_data;
    logic                byte_take;
    logic                is_cr;
    logic                slot;
    logic                slot_take;
    logic                kw_ok;
    logic                cmd_err;
    logic                cmd_rst;
    logic                cmd_plain;
    logic                cmd_addr;
    logic                cmd_entry;
    logic                id_range_bad;

    function automatic logic [7:0] kw_byte(input logic [87:0] kw, input logic [4:0] idx);
        int pos;
        pos = 87 - 8 * int'(idx);
        kw_byte = kw[pos -: 8];
    endfunction

    // ***********************************************
    // Receive buffer
    // ***********************************************
    imh_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .in_data   (rx_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_data)
    );

    // Bytes stall in the buffer while a mode switch is pending
    assign fifo_ready     = (st_reg.mode == imh_pkg::IMH_NORM) || (st_reg.mode == imh_pkg::IMH_MUTE) ||
                            ((st_reg.mode == imh_pkg::IMH_MAINT) && maint_rx_ready);
    assign maint_rx_valid = fifo_valid && (st_reg.mode == imh_pkg::IMH_MAINT);
    assign maint_rx_data  = fifo_data;
    assign byte_take      = fifo_valid && fifo_ready && (st_reg.mode == imh_pkg::IMH_NORM);

    // ***********************************************
    // Command decode at carriage return
    // ***********************************************
    // CR executes
    assign is_cr        = (fifo_data == `IMH_CHAR_CR);
    assign kw_ok        = st_reg.line.text_ok || st_reg.line.binary_ok;
    assign cmd_err      = (st_reg.line.len == 5'h01) && (st_reg.line.first == `IMH_CHAR_E);
    assign cmd_rst      = (st_reg.line.len == 5'h01) && (st_reg.line.first == `IMH_CHAR_R);
    // Plain entry taken regardless of line sharing
    assign cmd_plain    = (st_reg.line.len == `IMH_KW_LEN) && kw_ok;
    assign id_range_bad = (st_reg.line.idv > `IMH_ID_MAX);
    assign cmd_addr     = (st_reg.line.len > `IMH_KW_LEN + 5'h01) && kw_ok && !st_reg.line.ovf &&
                          !st_reg.line.bad && (st_reg.line.ndig != 2'h0) && !id_range_bad;
    assign cmd_entry    = cmd_plain || cmd_addr;

    // Trigger input replaces the periodic slot
    assign slot      = ext_trig_mode ? ext_trig : slot_tick;
    assign slot_take = (st_reg.mode == imh_pkg::IMH_NORM) && slot && !tx_busy;

    // ***********************************************
    // Next state
    // ***********************************************
    always_comb
    begin
        st_next              = st_reg;
        st_next.dg           = '{start: 1'b0, kind: imh_pkg::IMH_DG_NONE};
        st_next.err_clear    = 1'b0;
        st_next.unit_reset   = 1'b0;
        st_next.enter_text   = 1'b0;
        st_next.enter_binary = 1'b0;

        if (st_reg.err_sending && tx_done)
        begin
            st_next.err_sending = 1'b0;
            st_next.err_clear   = 1'b1;
        end

        if (slot_take)
        begin
            st_next.dg.start = 1'b1;
            if (st_reg.err_pend)
            begin
                st_next.dg.kind     = imh_pkg::IMH_DG_ERR;
                st_next.err_pend    = 1'b0;
                st_next.err_sending = 1'b1;
            end
            else
            begin
                st_next.dg.kind = imh_pkg::IMH_DG_MEAS;
            end
        end

        if (byte_take && is_cr)
        begin
            // Queue one error datagram; request wins over a take
            if (cmd_err)
            begin
                st_next.err_pend = 1'b1;
            end
            if (cmd_rst)
            begin
                st_next.unit_reset = 1'b1;
            end
            // Entry starts by finishing the datagram
            if (cmd_entry)
            begin
                st_next.mode = imh_pkg::IMH_FINISH;
                st_next.text = st_reg.line.text_ok;
                st_next.addr = cmd_addr;
                st_next.mine = !cmd_addr || (st_reg.line.idv[7:0] == module_identifier);
            end
            st_next.line = LINE_CLEAR;
        end
        else if (byte_take)
        begin
            // Length saturates; an over-long line can never match
            if (st_reg.line.len == `IMH_LINE_MAX - 5'h01)
            begin
                st_next.line.ovf = 1'b1;
            end
            else
            begin
                st_next.line.len = st_reg.line.len + 5'h01;
            end
            if (st_reg.line.len == 5'h00)
            begin
                st_next.line.first = fifo_data;
            end
            if (st_reg.line.len < `IMH_KW_LEN)
            begin
                st_next.line.text_ok   = st_reg.line.text_ok &&
                                         (fifo_data == kw_byte(`IMH_KW_TEXT, st_reg.line.len));
                st_next.line.binary_ok = st_reg.line.binary_ok &&
                                         (fifo_data == kw_byte(`IMH_KW_BINARY, st_reg.line.len));
            end
            else if (st_reg.line.len == `IMH_KW_LEN)
            begin
                st_next.line.bad = (fifo_data != `IMH_CHAR_SP);
            end
            else if ((fifo_data >= `IMH_CHAR_ZERO) && (fifo_data <= `IMH_CHAR_NINE) &&
                     (st_reg.line.ndig != `IMH_ID_DIGITS_MAX))
            begin
                st_next.line.idv  = 10'(st_reg.line.idv * 10'd10) + 10'(fifo_data - `IMH_CHAR_ZERO);
                st_next.line.ndig = st_reg.line.ndig + 2'h1;
            end
            else
            begin
                st_next.line.bad = 1'b1;
            end
        end

        unique case (st_reg.mode)
            imh_pkg::IMH_NORM:
            begin
            end
            imh_pkg::IMH_FINISH:
            begin
                // A start issued on the entry edge is still in flight
                if (!tx_busy && !st_reg.dg.start)
                begin
                    if (!st_reg.mine)
                    begin
                        st_next.mode = imh_pkg::IMH_MUTE;
                    end
                    else if (st_reg.addr)
                    begin
                        st_next.mode = imh_pkg::IMH_HOLD;
                        st_next.dly  = 24'h000000;
                    end
                    else
                    begin
                        st_next.mode         = imh_pkg::IMH_MAINT;
                        st_next.enter_text   = st_reg.text;
                        st_next.enter_binary = !st_reg.text;
                    end
                end
            end
            imh_pkg::IMH_HOLD:
            begin
                st_next.dly = st_reg.dly + 24'h000001;
                if (st_reg.dly >= DLY_LAST)
                begin
                    st_next.mode         = imh_pkg::IMH_MAINT;
                    st_next.enter_text   = st_reg.text;
                    st_next.enter_binary = !st_reg.text;
                end
            end
            // Maintenance and silent modules resume on exit without reply
            imh_pkg::IMH_MAINT,
            imh_pkg::IMH_MUTE:
            begin
                if (maint_exit)
                begin
                    st_next.mode = imh_pkg::IMH_NORM;
                end
            end
            default:
            begin
                st_next.mode = imh_pkg::IMH_NORM;
            end
        endcase

        if (st_reg.mode != imh_pkg::IMH_NORM)
        begin
            st_next.line = LINE_CLEAR;
        end

        st_next.levels.text_active   = (st_next.mode == imh_pkg::IMH_MAINT) && st_next.text;
        st_next.levels.binary_active = (st_next.mode == imh_pkg::IMH_MAINT) && !st_next.text;
        st_next.levels.muted         = (st_next.mode == imh_pkg::IMH_MUTE);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            st_reg      <= '0;
            st_reg.line <= LINE_CLEAR;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ***********************************************
    // Outputs
    // ***********************************************
    assign dg_start                     = st_reg.dg;
    assign err_clear                    = st_reg.err_clear;
    assign unit_reset                   = st_reg.unit_reset;
    // Text entry pulse also starts the listing
    assign enter_maintenance_text_cmd   = st_reg.enter_text;
    assign enter_maintenance_binary_cmd = st_reg.enter_binary;
    assign mode_levels                  = st_reg.levels;

    // ***********************************************
    // Assertions
    // ***********************************************
    a_err_clear_after: assert property (@(posedge clk_sys) disable iff (!rstn)
        (st_reg.err_sending && tx_done) |=> (err_clear && !st_reg.err_sending))
        else $error("record not cleared after error datagram");

    a_err_takes_slot: assert property (@(posedge clk_sys) disable iff (!rstn)
        (slot_take && st_reg.err_pend) |=> (dg_start.start && dg_start.kind == imh_pkg::IMH_DG_ERR))
        else $error("pending error datagram did not take the slot");

    a_no_start_busy: assert property (@(posedge clk_sys) disable iff (!rstn)
        dg_start.start |-> !$past(tx_busy))
        else $error("datagram started while transmitter busy");

    a_trig_only_slot: assert property (@(posedge clk_sys) disable iff (!rstn)
        (ext_trig_mode && !ext_trig) |=> !dg_start.start)
        else $error("datagram started without trigger");

    a_reset_cmd: assert property (@(posedge clk_sys) disable iff (!rstn)
        (byte_take && is_cr && cmd_rst) |=> unit_reset)
        else $error("reset command not acted on");

    a_finish_first: assert property (@(posedge clk_sys) disable iff (!rstn)
        (st_reg.mode == imh_pkg::IMH_FINISH && tx_busy) |=> !enter_maintenance_text_cmd &&
        !enter_maintenance_binary_cmd && st_reg.mode == imh_pkg::IMH_FINISH)
        else $error("mode switched during datagram");

    a_hold_length: assert property (@(posedge clk_sys) disable iff (!rstn)
        (st_reg.mode == imh_pkg::IMH_HOLD ##1 st_reg.mode == imh_pkg::IMH_MAINT) |->
        ($past(st_reg.dly) == DLY_LAST))
        else $error("addressed entry delay wrong");

    a_mute_silent: assert property (@(posedge clk_sys) disable iff (!rstn)
        mode_levels.muted |-> (!dg_start.start && !enter_maintenance_text_cmd && !unit_reset))
        else $error("muted module sent output");

    a_id_range: assert property (@(posedge clk_sys) disable iff (!rstn)
        (byte_take && is_cr && kw_ok && id_range_bad && st_reg.line.len > `IMH_KW_LEN) |=>
        (st_reg.mode == imh_pkg::IMH_NORM))
        else $error("out-of-range identifier accepted");

    a_plain_no_delay: assert property (@(posedge clk_sys) disable iff (!rstn)
        (byte_take && is_cr && cmd_plain && !tx_busy && !slot_take && !dg_start.start) |=> ##1
        (st_reg.mode == imh_pkg::IMH_MAINT))
        else $error("plain entry was delayed");

endmodule // imh_cmd_handler

/* File: sim/imh_tx_model.sv */
`timescale 1ns/10ps

module imh_tx_model #(
    parameter int LEN = 40
) (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rstn,
    // Transmitter handshake
    input  wire imh_pkg::imh_dgram_s  dg_start,
    output logic                      tx_busy,
    output logic                      tx_done
);
    int cnt;

    always_ff @(posedge clk_sys)
    begin
        tx_done <= 1'b0;
        if (!rstn)
        begin
            tx_busy <= 1'b0;
            cnt     <= 0;
        end
        else if (dg_start.start)
        begin
            tx_busy <= 1'b1;
            cnt     <= LEN;
        end
        else if (tx_busy)
        begin
            cnt <= cnt - 1;
            if (cnt == 1)
            begin
                tx_busy <= 1'b0;
                tx_done <= 1'b1;
            end
        end
    end
endmodule // imh_tx_model

/* File: sim/imh_cmd_handler_tb.sv */
`timescale 1ns/10ps

`include "imh_consts.svh"

module imh_cmd_handler_tb;
    logic clk_sys, rstn, rx_valid, rx_ready, ext_trig_mode, slot_tick, ext_trig, tx_busy, tx_done;
    logic err_clear, unit_reset, ent_t, ent_b, maint_exit, m_valid, m_ready;
    logic [7:0] rx_data, module_identifier, m_data;
    imh_pkg::imh_dgram_s dg_start;
    imh_pkg::imh_mode_s  mode_levels;
    int errors, checks_done, seed, n_clr, n_rst, n_t, n_b, x_clr, n_m;
    logic [1:0] exp_q[$];
    bit norm, pend;
    logic [7:0] own;
    logic [7:0] last_m;

    imh_cmd_handler #(.DGRAM_DELAY_CYC(10), .FIFO_DEPTH(8)) u_dut (.clk_sys(clk_sys), .rstn(rstn),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .module_identifier(module_identifier),
        .ext_trig_mode(ext_trig_mode), .slot_tick(slot_tick), .ext_trig(ext_trig), .tx_busy(tx_busy),
        .tx_done(tx_done), .dg_start(dg_start), .err_clear(err_clear), .unit_reset(unit_reset),
        .enter_maintenance_text_cmd(ent_t), .enter_maintenance_binary_cmd(ent_b), .mode_levels(mode_levels),
        .maint_exit(maint_exit), .maint_rx_valid(m_valid), .maint_rx_ready(m_ready), .maint_rx_data(m_data));
    imh_tx_model #(.LEN(40)) u_tx (.clk_sys(clk_sys), .rstn(rstn), .dg_start(dg_start),
        .tx_busy(tx_busy), .tx_done(tx_done));

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        checks_done++;
        if (e !== s)
        begin
            errors++;
            $display("ERROR %s expected %0h seen %0h", n, e, s);
        end
    endtask

    task automatic print_verdict();
        if (errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wt(int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Byte held until taken; host never lets go early
    task automatic send(string s);
        for (int i = 0; i < s.len(); i++)
        begin
            rx_valid = 1'b1;
            rx_data  = s[i];
            while (rx_ready !== 1'b1) @(negedge clk_sys);
            @(negedge clk_sys);
        end
        rx_valid = 1'b0;
        wt(4);
    endtask

    // Model of slot take: only when idle and in normal mode
    task automatic tick(bit trig);
        if (trig) ext_trig = 1'b1; else slot_tick = 1'b1;
        if (norm && tx_busy === 1'b0 && trig == ext_trig_mode)
        begin
            exp_q.push_back(pend ? 2'h2 : 2'h1);
            x_clr += pend;
            pend = 0;
        end
        @(negedge clk_sys);
        slot_tick = 1'b0;
        ext_trig  = 1'b0;
    endtask

    task automatic idle();
        wt(3);
        while (tx_busy === 1'b1) @(negedge clk_sys);
        wt(3);
    endtask

    task automatic leave();
        maint_exit = 1'b1;
        @(negedge clk_sys);
        maint_exit = 1'b0;
        norm = 1;
        wt(2);
    endtask

    always @(negedge clk_sys)
        if (rstn === 1'b1)
        begin
            if (dg_start.start === 1'b1)
                chk("dg_kind", exp_q.size() ? exp_q.pop_front() : 2'h3, dg_start.kind);
            if ((ent_t === 1'b1 || ent_b === 1'b1) && tx_busy !== 1'b0)
                chk("entry_busy", 0, 1);
            n_clr += err_clear;
            n_rst += unit_reset;
            n_t   += ent_t;
            n_b   += ent_b;
            // Ready is held high, so every valid byte is taken
            if (m_valid === 1'b1)
            begin
                n_m++;
                last_m = m_data;
            end
        end

    initial
    begin
        repeat (50000) @(posedge clk_sys);
        errors++;
        print_verdict();
    end

    initial
    begin
        {rx_valid, ext_trig_mode, slot_tick, ext_trig, maint_exit, rx_data} = '0;
        m_ready = 1'b1;
        rstn = 1'b0;
        seed = 82171;
        own = 8'($random(seed));
        module_identifier = own;
        norm = 1;
        wt(12);
        rstn = 1'b1;
        wt(2);
        chk("levels_rst", 0, mode_levels);
        tick(0); idle();
        send("E\r"); pend = 1;
        tick(0); idle(); tick(0); idle();
        chk("err_clear", x_clr, n_clr);
        send("e\r"); tick(0); idle();
        tick(0); wt(4); tick(0); idle();
        send("R\r");
        chk("unit_reset", 1, n_rst);
        send($sformatf("%s 256\r", `IMH_KW_BINARY)); wt(20);
        chk("bin_bad_id", 0, n_b);
        tick(0); wt(2); send($sformatf("%s\r", `IMH_KW_TEXT)); norm = 0; idle();
        chk("text_entry", 1, n_t);
        chk("text_level", 1, mode_levels.text_active);
        tick(0); wt(50); leave();
        send($sformatf("%s %0d\r", `IMH_KW_BINARY, own)); norm = 0; wt(4);
        chk("bin_early", 0, n_b);
        wt(20);
        chk("bin_entry", 1, n_b);
        chk("bin_level", 1, mode_levels.binary_active);
        send("?\r");
        chk("maint_byte", `IMH_CHAR_CR, last_m);
        leave();
        send($sformatf("%s %0d\r", `IMH_KW_TEXT, own ^ 8'h01)); norm = 0; wt(10);
        chk("muted", 1, mode_levels.muted);
        tick(0); wt(50); send("E\r"); leave();
        chk("muted_end", 0, mode_levels);
        chk("text_silent", 1, n_t);
        tick(0); idle();
        ext_trig_mode = 1'b1;
        send("E\r"); pend = 1;
        tick(0); wt(4); tick(1); idle();
        send($sformatf("%s 1234\r", `IMH_KW_BINARY)); wt(20);
        chk("bin_digits", 1, n_b);
        chk("err_clear_ext", x_clr, n_clr);
        chk("dg_left", 0, exp_q.size());
        chk("maint_bytes", 2, n_m);
        print_verdict();
    end
endmodule // imh_cmd_handler_tb
